// ==== shared/indicator_pkg.sv ====
// indicator_pkg: constants and types for the gripper status lamps and the
// converter mode switch decoder.
// assumes a single 25 MHz clock and a synchronous active-high reset.
package indicator_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 25000000;
  // blink half period in ms, acknowledge pulse in ms
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned ACK_PULSE_MS = 40;
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int unsigned ACK_PULSE_CYC = CLK_HZ / 1000 * ACK_PULSE_MS;
  localparam int CNT_W = 24;

  // ****************************************************************
  // switch codes, written as printed (first switch is bit 3)
  // ****************************************************************
  localparam logic [3:0] SW_PARAM_CFG = 4'h0;
  localparam logic [3:0] SW_USB = 4'h8;
  localparam logic [3:0] SW_TCP_CLIENT = 4'h4;
  localparam logic [3:0] SW_TCP_SERVER = 4'hc;
  localparam logic [3:0] SW_RS485 = 4'h2;
  localparam logic [3:0] SW_RS485_MODBUS = 4'ha;
  localparam logic [3:0] SW_IO = 4'h6;
  localparam logic [3:0] SW_CAN = 4'he;

  // number of stored parameter groups reachable over discrete i/o
  localparam int unsigned IO_GROUPS = 4;

  typedef enum logic [2:0]
  {
    MODE_PARAM_CFG,
    MODE_USB,
    MODE_TCP_CLIENT,
    MODE_TCP_SERVER,
    MODE_RS485,
    MODE_RS485_MODBUS,
    MODE_IO,
    MODE_CAN
  } work_mode_t;

endpackage : indicator_pkg

// ==== rtl/mode_switch_decoder.sv ====
// mode_switch_decoder: latches the 4-bit mode switch once after reset and
// decodes it into a working mode and the usb-present flag.
// assumes the switch is steady and synchronous to mclk during power-up.
`timescale 1ns/1ps
module mode_switch_decoder
  import indicator_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] mode_switch,
  output work_mode_t work_mode,
  output logic mode_valid,
  output logic usb_enable
);

  // ****************************************************************
  // decode
  // ****************************************************************
  function automatic work_mode_t decode_switch(input logic [3:0] code);
    case (code)
      SW_PARAM_CFG: decode_switch = MODE_PARAM_CFG;
      SW_USB: decode_switch = MODE_USB;
      SW_TCP_CLIENT: decode_switch = MODE_TCP_CLIENT;
      SW_TCP_SERVER: decode_switch = MODE_TCP_SERVER;
      SW_RS485: decode_switch = MODE_RS485;
      SW_RS485_MODBUS: decode_switch = MODE_RS485_MODBUS;
      SW_IO: decode_switch = MODE_IO;
      SW_CAN: decode_switch = MODE_CAN;
      // odd codes are not listed; fall back to configuration mode
      default: decode_switch = MODE_PARAM_CFG;
    endcase
  endfunction : decode_switch

  work_mode_t next_work_mode;
  logic next_mode_valid;
  logic next_usb_enable;

  // capture only on the first cycle after reset; later moves are ignored
  always_comb
  begin
    next_work_mode = work_mode;
    next_mode_valid = mode_valid;
    next_usb_enable = usb_enable;
    if (!mode_valid)
    begin
      // (RL7) switch code decode
      next_work_mode = decode_switch(mode_switch);
      // (RL8) power-up sample only
      next_mode_valid = 1'b1;
      // (RL9) usb gated by mode
      next_usb_enable = (mode_switch == SW_PARAM_CFG) ||
                        (mode_switch == SW_USB);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      work_mode <= MODE_PARAM_CFG;
      mode_valid <= 1'b0;
      usb_enable <= 1'b0;
    end
    else
    begin
      work_mode <= next_work_mode;
      mode_valid <= next_mode_valid;
      usb_enable <= next_usb_enable;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_mode_hold;
    @(posedge mclk) disable iff (reset)
      $past(mode_valid) |-> $stable(work_mode) && $stable(usb_enable);
  endproperty
  a_mode_hold: assert property (p_mode_hold) // RL8
    else $error("mode changed after power-up capture");

  property p_usb_gate;
    @(posedge mclk) disable iff (reset)
      mode_valid && usb_enable |->
        (work_mode == MODE_PARAM_CFG || work_mode == MODE_USB);
  endproperty
  a_usb_gate: assert property (p_usb_gate) // RL9
    else $error("usb function present in wrong mode");

  // unlisted codes land in configuration mode but keep usb off, so the
  // exact check looks at the raw code taken at capture
  property p_usb_code;
    @(posedge mclk) disable iff (reset)
      !mode_valid |=> usb_enable ==
        ($past(mode_switch) == SW_PARAM_CFG || $past(mode_switch) == SW_USB);
  endproperty
  a_usb_code: assert property (p_usb_code) // RL9
    else $error("usb function does not follow captured code");

  property p_decode_io;
    @(posedge mclk) disable iff (reset)
      !mode_valid && mode_switch == SW_IO |=> work_mode == MODE_IO;
  endproperty
  a_decode_io: assert property (p_decode_io) // RL7
    else $error("io switch code decoded wrongly");

  c_usb_mode: cover property (@(posedge mclk) mode_valid && usb_enable);

endmodule : mode_switch_decoder

// ==== rtl/gripper_indicator.sv ====
// gripper_indicator: drives the red, green and blue status lamps from the
// gripper state, gates commands until initialization, and hosts the mode
// switch decoder of the protocol converter.
// assumes status inputs are one-cycle pulses synchronous to mclk.
//
// Behaviour
// (RL1) uninitialized: red blinks, green and blue off
// (RL2) initialized: blue steadily lit, commands accepted
// (RL3) each accepted command gives one short red pulse, blue stays lit
// (RL4) object held: green steady, red and blue forced off
// (RL5) held object lost: green blinks
// (RL6) host must initialize after power-up; uninitialized until done
// (RL7) mode switch decodes into eight working modes
// (RL8) mode switch read only at power-up
// (RL9) usb function present only in configuration or usb mode
// (RL10) discrete i/o mode selects among only four parameter groups
// (RL11) blink and pulse lengths are cycle counts, pulse shorter
`timescale 1ns/1ps
module gripper_indicator
  import indicator_pkg::*;
#(
  parameter int unsigned BLINK_CYC = BLINK_HALF_CYC,
  parameter int unsigned PULSE_CYC = ACK_PULSE_CYC
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic init_done,
  input wire logic cmd_valid,
  input wire logic object_held,
  input wire logic object_lost,
  input wire logic [1:0] io_group_sel,
  input wire logic [3:0] mode_switch,
  output logic cmd_accept,
  output logic initialized,
  output logic [1:0] param_group,
  output logic lamp_red,
  output logic lamp_green,
  output logic lamp_blue,
  output work_mode_t work_mode,
  output logic mode_valid,
  output logic usb_enable
);

  typedef enum logic [1:0]
  {
    ST_UNINIT,
    ST_READY,
    ST_HELD,
    ST_DROPPED
  } grip_state_t;

  // ****************************************************************
  // converter mode
  // ****************************************************************
  mode_switch_decoder u_mode
  (
    .mclk(mclk),
    .reset(reset),
    .mode_switch(mode_switch),
    .work_mode(work_mode),
    .mode_valid(mode_valid),
    .usb_enable(usb_enable)
  );

  // ****************************************************************
  // gripper state
  // ****************************************************************
  grip_state_t state;
  grip_state_t next_state;

  // (RL6) commands gated until init
  assign cmd_accept = cmd_valid && (state != ST_UNINIT);
  assign initialized = (state != ST_UNINIT);

  // a loss only counts while holding, so a spurious report stays ignored
  always_comb
  begin
    next_state = state;
    case (state)
      ST_UNINIT:
        // (RL6) leave uninit on completion
        if (init_done)
          next_state = ST_READY;
      ST_READY:
        if (object_held)
          next_state = ST_HELD;
      ST_HELD:
        // (RL5) detect object drop
        if (object_lost)
          next_state = ST_DROPPED;
        else if (cmd_valid)
          next_state = ST_READY;
      ST_DROPPED:
        if (cmd_valid)
          next_state = ST_READY;
      default:
        next_state = ST_UNINIT;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      state <= ST_UNINIT;
    else
      state <= next_state;
  end

  // ****************************************************************
  // timers
  // ****************************************************************
  logic [CNT_W-1:0] blink_cnt;
  logic [CNT_W-1:0] next_blink_cnt;
  logic blink;
  logic next_blink;
  logic [CNT_W-1:0] pulse_cnt;
  logic [CNT_W-1:0] next_pulse_cnt;

  // (RL11) blink and pulse counters
  always_comb
  begin
    next_blink_cnt = blink_cnt + 1'b1;
    next_blink = blink;
    if (blink_cnt >= CNT_W'(BLINK_CYC - 1))
    begin
      next_blink_cnt = '0;
      next_blink = !blink;
    end
    next_pulse_cnt = pulse_cnt;
    // (RL3) retrigger pulse on command
    if (cmd_accept)
      next_pulse_cnt = CNT_W'(PULSE_CYC);
    else if (pulse_cnt != '0)
      next_pulse_cnt = pulse_cnt - 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      blink_cnt <= '0;
      blink <= 1'b0;
      pulse_cnt <= '0;
    end
    else
    begin
      blink_cnt <= next_blink_cnt;
      blink <= next_blink;
      pulse_cnt <= next_pulse_cnt;
    end
  end

  // ****************************************************************
  // lamps and parameter group
  // ****************************************************************
  logic next_red;
  logic next_green;
  logic next_blue;
  logic [1:0] next_param_group;

  // lamps registered so the pins never glitch on state decode
  always_comb
  begin
    next_red = 1'b0;
    next_green = 1'b0;
    next_blue = 1'b0;
    case (state)
      // (RL1) red blink only
      ST_UNINIT: next_red = blink;
      ST_READY:
      begin
        // (RL2) blue steady on
        next_blue = 1'b1;
        // (RL3) red ack pulse
        next_red = (pulse_cnt != '0);
      end
      // (RL4) green only while held
      ST_HELD: next_green = 1'b1;
      // (RL5) green blinks on drop
      ST_DROPPED: next_green = blink;
      default: next_red = 1'b0;
    endcase
    next_param_group = param_group;
    // (RL10) four groups in io mode
    if (work_mode == MODE_IO && mode_valid)
      next_param_group = io_group_sel;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      lamp_red <= 1'b0;
      lamp_green <= 1'b0;
      lamp_blue <= 1'b0;
      param_group <= 2'h0;
    end
    else
    begin
      lamp_red <= next_red;
      lamp_green <= next_green;
      lamp_blue <= next_blue;
      param_group <= next_param_group;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_uninit_lamps;
    @(posedge mclk) disable iff (reset)
      state == ST_UNINIT ##1 state == ST_UNINIT |-> !lamp_green && !lamp_blue;
  endproperty
  a_uninit_lamps: assert property (p_uninit_lamps) // RL1
    else $error("green or blue lit before init");

  property p_ready_blue;
    @(posedge mclk) disable iff (reset)
      state == ST_READY |=> lamp_blue;
  endproperty
  a_ready_blue: assert property (p_ready_blue) // RL2
    else $error("blue not lit when initialized");

  property p_ack_pulse;
    @(posedge mclk) disable iff (reset)
      cmd_accept && state == ST_READY && !object_held ##1 state == ST_READY
        |=> lamp_red && lamp_blue;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) // RL3
    else $error("no red acknowledge pulse");

  property p_held_lamps;
    @(posedge mclk) disable iff (reset)
      state == ST_HELD |=> lamp_green && !lamp_red && !lamp_blue;
  endproperty
  a_held_lamps: assert property (p_held_lamps) // RL4
    else $error("held lamps wrong");

  property p_drop;
    @(posedge mclk) disable iff (reset)
      state == ST_HELD && object_lost |=> state == ST_DROPPED;
  endproperty
  a_drop: assert property (p_drop) // RL5
    else $error("drop not reported");

  property p_gate;
    @(posedge mclk) disable iff (reset)
      state == ST_UNINIT |-> !cmd_accept;
  endproperty
  a_gate: assert property (p_gate) // RL6
    else $error("command accepted before init");

  property p_pulse_short;
    @(posedge mclk) disable iff (reset)
      pulse_cnt <= CNT_W'(PULSE_CYC) && PULSE_CYC < BLINK_CYC;
  endproperty
  a_pulse_short: assert property (p_pulse_short) // RL11
    else $error("pulse not shorter than blink");

  property p_group;
    @(posedge mclk) disable iff (reset)
      mode_valid && work_mode == MODE_IO |=> param_group == $past(io_group_sel);
  endproperty
  a_group: assert property (p_group) // RL10
    else $error("parameter group not followed");

  c_init: cover property (@(posedge mclk) state == ST_UNINIT && init_done);
  c_ack: cover property (@(posedge mclk) cmd_accept);
  c_held: cover property (@(posedge mclk) state == ST_HELD);
  c_drop: cover property (@(posedge mclk) state == ST_DROPPED && lamp_green);

endmodule : gripper_indicator

// ==== testbench/host_model.sv ====
// host_model: stands in for the host controller that sends the
// initialization command and the operating commands.
// assumes the bench calls its tasks from one process only.
`timescale 1ns/1ps
module host_model
(
  input wire logic mclk,
  input wire logic cmd_accept,
  output logic init_done,
  output logic cmd_valid
);
  // ****************************************************************
  // host requests
  // ****************************************************************
  // idle until the bench asks for something
  initial
  begin
    init_done = 1'b0;
    cmd_valid = 1'b0;
  end

  // init before use
  // a gap lets the host answer slowly; completion is a one-cycle pulse
  task automatic send_init(input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    #1 init_done = 1'b1;
    @(posedge mclk);
    #1 init_done = 1'b0;
  endtask : send_init

  // one command per high cycle; accept is combinational, read mid-cycle
  task automatic send_cmd(output logic acc);
    @(posedge mclk);
    #1 cmd_valid = 1'b1;
    #1 acc = cmd_accept;
    @(posedge mclk);
    #1 cmd_valid = 1'b0;
  endtask : send_cmd
endmodule : host_model

// ==== testbench/test_gripper_indicator.sv ====
// test_gripper_indicator: self-checking bench for the status lamps and
// the converter mode switch decoder.
// assumes short blink and pulse counts so each scenario stays brief.
`timescale 1ns/1ps
module test_gripper_indicator;
  import indicator_pkg::*;
  localparam int unsigned BLINK = 8;
  localparam int unsigned PULSE = 3;
  logic mclk = 1'b0;
  logic reset, object_held, object_lost;
  logic [1:0] io_group_sel, param_group;
  logic [3:0] mode_switch;
  logic init_done, cmd_valid, cmd_accept, initialized;
  logic lamp_red, lamp_green, lamp_blue, mode_valid, usb_enable;
  work_mode_t work_mode;
  int n_fail = 0;
  int num_checks = 0;

  // ****************************************************************
  // design and host
  // ****************************************************************
  gripper_indicator #(.BLINK_CYC(BLINK), .PULSE_CYC(PULSE)) u_dut (
    .mclk(mclk), .reset(reset), .init_done(init_done),
    .cmd_valid(cmd_valid), .object_held(object_held),
    .object_lost(object_lost), .io_group_sel(io_group_sel),
    .mode_switch(mode_switch), .cmd_accept(cmd_accept),
    .initialized(initialized), .param_group(param_group),
    .lamp_red(lamp_red), .lamp_green(lamp_green), .lamp_blue(lamp_blue),
    .work_mode(work_mode), .mode_valid(mode_valid),
    .usb_enable(usb_enable));
  host_model u_host (.mclk(mclk), .cmd_accept(cmd_accept),
    .init_done(init_done), .cmd_valid(cmd_valid));

  // 25 mhz clock
  always #20 mclk = ~mclk;

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // reset for three cycles with a switch code; ends on first free edge
  task automatic do_reset(input logic [3:0] code);
    @(posedge mclk);
    #1 reset = 1'b1;
    mode_switch = code;
    repeat (3) @(posedge mclk);
    #1 reset = 1'b0;
    @(posedge mclk);
    #1;
  endtask : do_reset

  // counts lit cycles; a blinking lamp lands strictly between 0 and n
  task automatic watch(input int n, output int r, output int g,
    output int b);
    r = 0;
    g = 0;
    b = 0;
    repeat (n)
    begin
      @(posedge mclk);
      #1;
      r += int'(lamp_red === 1'b1);
      g += int'(lamp_green === 1'b1);
      b += int'(lamp_blue === 1'b1);
    end
  endtask : watch

  // one-cycle status event on a gripper input
  task automatic pulse_event(ref logic sig);
    @(posedge mclk);
    #1 sig = 1'b1;
    @(posedge mclk);
    #1 sig = 1'b0;
  endtask : pulse_event

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // every switch code, then a late switch change that must be ignored
  task automatic test_modes();
    logic [3:0] codes [8] = '{4'h0, 4'h8, 4'h4, 4'hc, 4'h2, 4'ha, 4'h6,
      4'he};
    for (int i = 0; i < 8; i++)
    begin
      do_reset(codes[i]);
      check("mode_valid", 8'(mode_valid), 8'h01);
      check("work_mode", 8'(work_mode), 8'(i));
      check("usb_enable", 8'(usb_enable), 8'(i < 2));
      mode_switch = codes[(i + 3) % 8];
      repeat (3) @(posedge mclk);
      #1 check("mode_held", 8'(work_mode), 8'(i));
      check("usb_held", 8'(usb_enable), 8'(i < 2));
    end
    // an unlisted code falls back to configuration with usb kept off
    do_reset(4'h1);
    check("odd_mode", 8'(work_mode), 8'(MODE_PARAM_CFG));
    check("odd_usb", 8'(usb_enable), 8'h00);
  endtask : test_modes

  // uninitialized: red blinks, commands refused, then init shows blue
  task automatic test_init();
    int r, g, b;
    logic acc;
    do_reset(4'h6);
    watch(2 * BLINK + 4, r, g, b);
    check("red_blinks", 8'(r > 0 && r < 2 * BLINK + 4), 8'h01);
    check("green_off", 8'(g), 8'h00);
    check("blue_off", 8'(b), 8'h00);
    u_host.send_cmd(acc);
    check("early_cmd", 8'(acc), 8'h00);
    u_host.send_init(2);
    check("initialized", 8'(initialized), 8'h01);
    repeat (2) @(posedge mclk);
    #1 check("blue_on", 8'(lamp_blue), 8'h01);
    check("red_off", 8'(lamp_red), 8'h00);
  endtask : test_init

  // accepted command: one short red pulse while blue stays lit
  task automatic test_cmd();
    int r, g, b;
    logic acc;
    u_host.send_cmd(acc);
    check("cmd_accept", 8'(acc), 8'h01);
    watch(2 * BLINK, r, g, b);
    check("red_pulse", 8'(r), 8'(PULSE));
    check("blue_steady", 8'(b), 8'(2 * BLINK));
  endtask : test_cmd

  // object held then lost: green steady, then green blinking
  task automatic test_object();
    int r, g, b;
    logic acc;
    pulse_event(object_held);
    @(posedge mclk);
    watch(2 * BLINK, r, g, b);
    check("held_green", 8'(g), 8'(2 * BLINK));
    check("held_red", 8'(r), 8'h00);
    check("held_blue", 8'(b), 8'h00);
    pulse_event(object_lost);
    @(posedge mclk);
    watch(2 * BLINK + 4, r, g, b);
    check("drop_blink", 8'(g > 0 && g < 2 * BLINK + 4), 8'h01);
    // a command leaves the drop state; a stray loss report is ignored
    u_host.send_cmd(acc);
    check("drop_cmd", 8'(acc), 8'h01);
    pulse_event(object_lost);
    @(posedge mclk);
    #1 check("ready_blue", 8'(lamp_blue), 8'h01);
    check("ready_green", 8'(lamp_green), 8'h00);
  endtask : test_object

  // io mode: each of the four parameter groups follows the selector
  task automatic test_groups();
    for (int i = 0; i < 4; i++)
    begin
      io_group_sel = 2'(i);
      repeat (2) @(posedge mclk);
      #1 check("param_group", 8'(param_group), 8'(i));
    end
  endtask : test_groups

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial
  begin
    reset = 1'b1;
    object_held = 1'b0;
    object_lost = 1'b0;
    io_group_sel = 2'h0;
    mode_switch = 4'h0;
    test_modes();
    test_init();
    test_cmd();
    test_object();
    test_groups();
    give_verdict();
  end

  // whole run is under two hundred cycles; a thousand means a hang
  initial
  begin
    #40000;
    n_fail++;
    give_verdict();
  end
endmodule : test_gripper_indicator
